/* shared/sab_pkg.sv */
// Package for the converter bus interface: widths, timing and states
package sab_pkg;
  localparam int SAB_RES_W = 12;
  localparam int SAB_BUS_W = 12;
  localparam int SAB_MSB_W = 4;
  localparam int SAB_LSB_W = 8;
  localparam int SAB_CNT_W = 4;
  // Conversion clock and bit timing
  localparam int SAB_SYS_HZ = 40000000;
  localparam int SAB_CONV_HZ = 1250000;
  localparam int SAB_CONV_DIV = SAB_SYS_HZ / SAB_CONV_HZ;
  localparam int SAB_DIV_W = 6;
  localparam logic [SAB_DIV_W-1:0] SAB_DIV_LAST = 6'(SAB_CONV_DIV - 1);
  localparam logic [SAB_CNT_W-1:0] SAB_CONV_CLKS = 4'hD;
  localparam logic [SAB_CNT_W-1:0] SAB_FIRST_BIT_CLK = 4'h2;
  localparam logic [SAB_CNT_W-1:0] SAB_CNT_ZERO = 4'h0;
  localparam logic [SAB_CNT_W-1:0] SAB_CNT_ONE = 4'h1;
  localparam logic [SAB_RES_W-1:0] SAB_RES_ZERO = 12'h000;
  localparam logic [SAB_RES_W-1:0] SAB_RES_MSB = 12'h800;
  // Host idle gap between reads, in bus clocks
  localparam logic [9:0] SAB_HOST_GAP = 10'h200;
  localparam logic [9:0] SAB_GAP_ZERO = 10'h000;

  typedef enum logic [1:0] {
    SAB_H_IDLE,
    SAB_H_READ,
    SAB_H_WAIT
  } sab_host_state_e;

  // Data bus word as seen on the 12-bit host side
  function automatic logic [SAB_BUS_W-1:0] sab_bus_word(input logic [SAB_RES_W-1:0] res,
                                                       input logic upper);
    logic [SAB_BUS_W-1:0] w;
    w = {res[SAB_RES_W-1 -: SAB_MSB_W], res[SAB_LSB_W-1:0]};
    if (upper) begin
      w[SAB_LSB_W-1:0] = {4'h0, res[SAB_RES_W-1 -: SAB_MSB_W]};
    end
    return w;
  endfunction
endpackage

/* shared/sab_if.sv */
// Interface joining the converter and its host on the parallel bus
interface sab_if;
  logic sel_n;
  logic rd_n;
  logic upper_byte_select;
  logic busy_n;
  logic [11:0] result_data_outputs;
  logic data_oe;
  logic [11:0] host_bus;
  assign host_bus = data_oe ? result_data_outputs : 12'hFFF;
  modport dev (
    input sel_n,
    input rd_n,
    input upper_byte_select,
    output busy_n,
    output result_data_outputs,
    output data_oe
  );
  modport host (
    output sel_n,
    output rd_n,
    output upper_byte_select,
    input busy_n,
    input host_bus
  );
endinterface

/* core/sab_dev.sv */
// Converter end: conversion sequencer and three-state result bus
// Functional notes
// - Result as 12-bit word or byte pair
// - Result right justified, LSB rightmost
// - Upper byte select steers low-byte multiplexer
// - Top four outputs always carry MSBs
// - Eight-bit host reads two lower bytes
// - Read-ahead and wait-state styles supported
// - Read-ahead read returns previous, starts new
// - Host pairs reads, keeps second value
// - Wait-state read holds host until done
// - Select and read fall start conversion
// - Busy low during conversion, high latches
// - Thirteen clocks, MSB first, unstoppable
// - Upper byte read starts no conversion
module sab_dev
  import sab_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic [SAB_RES_W-1:0] i_analog_code,
  output logic o_conv_tick,
  sab_if.dev bus
);
  typedef struct packed {
    // Conversion clock divider
    logic [SAB_DIV_W-1:0] div;
    // One-cycle conversion clock enable
    logic tick;
    // Strobe seen last cycle, for the start edge
    logic strobe_d;
    logic busy;
    // Conversion clocks since start
    logic [SAB_CNT_W-1:0] clks;
    // Approximation register
    logic [SAB_RES_W-1:0] approx;
    // Bit under trial, walks from MSB down
    logic [SAB_RES_W-1:0] trial;
    // Output latch, updated only at end of conversion
    logic [SAB_RES_W-1:0] latch;
    logic busy_n;
    // Three-state enable of the result outputs
    logic oe;
    // Registered result outputs
    logic [SAB_BUS_W-1:0] data;
  } sab_dev_s;

  // Quiet bus after reset: busy released, outputs floating
  localparam sab_dev_s DEV_IDLE = '{
    div: '0,
    tick: 1'b0,
    strobe_d: 1'b0,
    busy: 1'b0,
    clks: SAB_CNT_ZERO,
    approx: SAB_RES_ZERO,
    trial: SAB_RES_ZERO,
    latch: SAB_RES_ZERO,
    busy_n: 1'b1,
    oe: 1'b0,
    data: SAB_RES_ZERO
  };

  sab_dev_s st_r;
  sab_dev_s st_nxt;

  // Decode results, kept apart from the state copy
  logic strobe;
  logic start_edge;
  logic tick_due;
  logic decide_now;
  logic last_clk;
  logic keep_bit;
  logic [SAB_RES_W-1:0] candidate;
  logic [SAB_RES_W-1:0] approx_nxt;
  logic [SAB_RES_W-1:0] latch_nxt;
  logic [SAB_BUS_W-1:0] word_nxt;

  // Both strobes low; enable and start detector share it
  function automatic logic dev_strobe(
    input logic sel_n,
    input logic rd_n
  );
    logic both_low;
    both_low = !sel_n && !rd_n;
    return both_low;
  endfunction

  // Bit trials run from the second tick to the thirteenth
  function automatic logic dev_decide(
    input logic busy,
    input logic tick,
    input logic [SAB_CNT_W-1:0] clks,
    input logic [SAB_RES_W-1:0] trial
  );
    logic in_window;
    logic bits_left;
    in_window = clks >= SAB_FIRST_BIT_CLK - SAB_CNT_ONE;
    bits_left = trial != SAB_RES_ZERO;
    return busy && tick && in_window && bits_left;
  endfunction

  // Thirteenth conversion clock ends the conversion
  function automatic logic dev_last(
    input logic busy,
    input logic tick,
    input logic [SAB_CNT_W-1:0] clks
  );
    logic at_end;
    at_end = clks == SAB_CONV_CLKS - SAB_CNT_ONE;
    return busy && tick && at_end;
  endfunction

  // One output bit: top lanes carry MSBs, low lanes follow the byte select
  function automatic logic dev_lane(
    input logic [SAB_RES_W-1:0] res,
    input logic upper,
    input int idx
  );
    logic bit_v;
    if (idx >= SAB_LSB_W) begin
      bit_v = res[idx];
    end else if (!upper) begin
      bit_v = res[idx];
    end else if (idx < SAB_MSB_W) begin
      bit_v = res[SAB_LSB_W + idx];
    end else begin
      bit_v = 1'b0;
    end
    return bit_v;
  endfunction

  assign strobe = dev_strobe(bus.sel_n, bus.rd_n);
  // Strobes while busy are ignored; upper byte reads start nothing
  assign start_edge = strobe && !st_r.strobe_d && !bus.upper_byte_select
    && !st_r.busy;
  assign tick_due = st_r.div == SAB_DIV_LAST;

  assign decide_now = dev_decide(st_r.busy, st_r.tick, st_r.clks, st_r.trial);
  assign last_clk = dev_last(st_r.busy, st_r.tick, st_r.clks);
  assign candidate = st_r.approx | st_r.trial;
  // Comparator stand-in: the trial bit stays when the input reaches it
  assign keep_bit = i_analog_code >= candidate;
  assign approx_nxt = (decide_now && keep_bit) ? candidate : st_r.approx;
  // New result reaches the latch with the last decision, so busy and data agree
  assign latch_nxt = last_clk ? approx_nxt : st_r.latch;

  // One lane per output bit; the top four always carry the MSBs
  for (genvar gi = 0; gi < SAB_BUS_W; gi++) begin : g_lane
    assign word_nxt[gi] = dev_lane(latch_nxt, bus.upper_byte_select, gi);
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.strobe_d = strobe;
    st_nxt.tick = tick_due;
    if (tick_due) begin
      st_nxt.div = '0;
    end else begin
      st_nxt.div = st_r.div + 1'b1;
    end

    if (st_r.busy) begin
      // No restart while busy: it would corrupt pending decisions
      if (st_r.tick) begin
        st_nxt.clks = st_r.clks + SAB_CNT_ONE;
      end
      if (decide_now) begin
        st_nxt.trial = st_r.trial >> 1;
      end
      st_nxt.approx = approx_nxt;
      if (last_clk) begin
        st_nxt.busy = 1'b0;
      end
    end else if (start_edge) begin
      st_nxt.busy = 1'b1;
      st_nxt.clks = SAB_CNT_ZERO;
      st_nxt.approx = SAB_RES_ZERO;
      st_nxt.trial = SAB_RES_MSB;
    end

    st_nxt.latch = latch_nxt;
    st_nxt.busy_n = !st_nxt.busy;
    // Enable lags the strobes by one clock, outputs stay registered
    st_nxt.oe = strobe;
    // Latch holds last result so a read-ahead read sees old data
    st_nxt.data = word_nxt;
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= DEV_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.busy_n = st_r.busy_n;
  assign bus.data_oe = st_r.oe;
  assign bus.result_data_outputs = st_r.data;
  assign o_conv_tick = st_r.tick;
endmodule

/* core/sab_host.sv */
// Host end: issues reads in read-ahead or wait-state style
module sab_host
  import sab_pkg::*;
(
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic i_req,
  input wire logic i_wait_mode,
  input wire logic i_byte_mode,
  output logic o_ready,
  output logic o_valid,
  output logic [SAB_RES_W-1:0] o_result,
  sab_if.host bus
);
  typedef struct packed {
    sab_host_state_e st;
    logic second;
    logic hi;
    logic held;
    logic [9:0] gap;
    logic [SAB_LSB_W-1:0] low;
    logic [SAB_RES_W-1:0] res;
    logic valid;
    logic sel_n;
    logic rd_n;
    logic ubs;
  } sab_host_s;

  sab_host_s st_r;
  sab_host_s st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.valid = 1'b0;
    if (st_r.gap != SAB_GAP_ZERO) begin
      st_nxt.gap = st_r.gap - 1'b1;
    end
    case (st_r.st)
      SAB_H_IDLE: begin
        if ((i_req || st_r.second || st_r.hi) && st_r.gap == SAB_GAP_ZERO) begin
          st_nxt.sel_n = 1'b0;
          st_nxt.rd_n = 1'b0;
          st_nxt.ubs = st_r.hi;
          st_nxt.st = SAB_H_READ;
        end
      end
      SAB_H_READ: begin
        // Sample one cycle after the device latches its enable
        st_nxt.held = !st_r.held;
        if (!st_r.held) begin
          st_nxt.st = SAB_H_READ;
        end else if (i_wait_mode && !st_r.hi) begin
          st_nxt.st = SAB_H_WAIT;
        end else begin
          st_nxt.st = SAB_H_IDLE;
          st_nxt.sel_n = 1'b1;
          st_nxt.rd_n = 1'b1;
          st_nxt.gap = SAB_HOST_GAP;
          if (st_r.hi) begin
            st_nxt.hi = 1'b0;
            st_nxt.res = {bus.host_bus[SAB_MSB_W-1:0], st_r.low};
            st_nxt.valid = 1'b1;
          end else if (st_r.second) begin
            // Only the second read of a pair is current
            st_nxt.second = 1'b0;
            st_nxt.low = bus.host_bus[SAB_LSB_W-1:0];
            st_nxt.res = bus.host_bus;
            st_nxt.hi = i_byte_mode;
            st_nxt.valid = !i_byte_mode;
          end else begin
            st_nxt.second = 1'b1;
          end
        end
      end
      SAB_H_WAIT: begin
        // Held until busy returns high
        if (bus.busy_n) begin
          st_nxt.sel_n = 1'b1;
          st_nxt.rd_n = 1'b1;
          st_nxt.st = SAB_H_IDLE;
          st_nxt.low = bus.host_bus[SAB_LSB_W-1:0];
          st_nxt.res = bus.host_bus;
          st_nxt.hi = i_byte_mode;
          st_nxt.valid = !i_byte_mode;
          st_nxt.gap = SAB_HOST_GAP;
        end
      end
      default: begin
        st_nxt.st = SAB_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      st_r <= '0;
      st_r.st <= SAB_H_IDLE;
      st_r.sel_n <= 1'b1;
      st_r.rd_n <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bus.sel_n = st_r.sel_n;
  assign bus.rd_n = st_r.rd_n;
  assign bus.upper_byte_select = st_r.ubs;
  assign o_ready = st_r.st == SAB_H_IDLE && !st_r.second && !st_r.hi;
  assign o_valid = st_r.valid;
  assign o_result = st_r.res;
endmodule

/* dv/sab_asserts.sv */
// Checker on the bus between converter and host
module sab_asserts (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic sel_n,
  input wire logic rd_n,
  input wire logic upper_byte_select,
  input wire logic busy_n,
  input wire logic [11:0] result_data_outputs,
  input wire logic data_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] low_cnt_r;
  logic [9:0] low_cnt_nxt;
  // Start phase against the conversion tick is free, so the length has a band
  assign low_cnt_nxt = busy_n ? 10'h000 : low_cnt_r + 10'h001;
  always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      low_cnt_r <= 10'h000;
    end else begin
      low_cnt_r <= low_cnt_nxt;
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_arst_n);
  property p_float; (sel_n || rd_n) |=> !data_oe; endproperty
  a_float: assert property (p_float) else $error("Bus driven without strobes");
  property p_start;
    !sel_n && !rd_n && $past(sel_n || rd_n) && !upper_byte_select && busy_n
      |=> !busy_n && data_oe;
  endproperty
  a_start: assert property (p_start) else $error("Read did not start conversion");
  property p_upper;
    !sel_n && !rd_n && $past(sel_n || rd_n) && upper_byte_select && busy_n |=> busy_n;
  endproperty
  a_upper: assert property (p_upper) else $error("Upper byte read started work");
  property p_mux;
    data_oe && $past(upper_byte_select)
      |-> result_data_outputs[7:0] == {4'h0, result_data_outputs[11:8]};
  endproperty
  a_mux: assert property (p_mux) else $error("Upper byte not on low lines");
  property p_len; $rose(busy_n) |-> low_cnt_r inside {[10'h17C:10'h1A4]}; endproperty
  a_len: assert property (p_len) else $error("Conversion length wrong");
  property p_max; !busy_n |-> low_cnt_r < 10'h1A4; endproperty
  a_max: assert property (p_max) else $error("Busy held too long");
  property p_hold;
    !busy_n && $past(!busy_n) && data_oe && $past(data_oe)
      && $past(upper_byte_select) == $past(upper_byte_select, 2)
      |-> $stable(result_data_outputs);
  endproperty
  a_hold: assert property (p_hold) else $error("Latch changed during conversion");
  property p_cause; $fell(busy_n) |-> $past(!sel_n && !rd_n); endproperty
  a_cause: assert property (p_cause) else $error("Busy fell without a read");
endmodule

/* dv/sar_adc_bus_interface_tb.sv */
// Bench joining converter end and host end
module sar_adc_bus_interface_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic req = 1'b0;
  logic wmode = 1'b0;
  logic bmode = 1'b0;
  logic [11:0] code = 12'h000;
  logic ready;
  logic valid;
  logic [11:0] res;
  logic tick;
  int n_errors = 0;
  int checks = 0;
  always #12.5 sys_clk = ~sys_clk;
  sab_if bus_if();
  sab_dev i_sab_dev (.i_sys_clk(sys_clk), .i_arst_n(arst_n), .i_analog_code(code),
    .o_conv_tick(tick), .bus(bus_if.dev));
  sab_host i_sab_host (.i_sys_clk(sys_clk), .i_arst_n(arst_n), .i_req(req),
    .i_wait_mode(wmode), .i_byte_mode(bmode), .o_ready(ready), .o_valid(valid),
    .o_result(res), .bus(bus_if.host));
  sab_asserts i_sab_asserts (.i_sys_clk(sys_clk), .i_arst_n(arst_n), .sel_n(bus_if.sel_n),
    .rd_n(bus_if.rd_n), .upper_byte_select(bus_if.upper_byte_select),
    .busy_n(bus_if.busy_n), .result_data_outputs(bus_if.result_data_outputs),
    .data_oe(bus_if.data_oe));
  task automatic chk(input logic [11:0] exp, input logic [11:0] got);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Wire view at end of a held read: new word, MSBs on top lines
  always @(posedge bus_if.busy_n) begin
    @(negedge sys_clk);
    if (arst_n && bus_if.data_oe === 1'b1) begin
      chk({code[11:8], bus_if.upper_byte_select ? {4'h0, code[11:8]} : code[7:0]},
        bus_if.host_bus);
    end
  end
  // Held request until taken, since the host only takes it when its gap ends
  task automatic measure(input logic w, input logic b, input logic [11:0] c);
    int n;
    code = c;
    wmode = w;
    bmode = b;
    req = 1'b1;
    n = 0;
    do begin
      @(negedge sys_clk);
      n++;
    end while (ready === 1'b1 && n < 3000);
    req = 1'b0;
    while (valid !== 1'b1 && n < 8000) begin
      @(negedge sys_clk);
      n++;
    end
    chk(c, res);
  endtask
  task automatic t_read_ahead();
    measure(1'b0, 1'b0, 12'h5A3);
    measure(1'b0, 1'b0, 12'hFFF);
    $display("read-ahead test done");
  endtask
  task automatic t_wait();
    measure(1'b1, 1'b0, 12'h000);
    measure(1'b1, 1'b0, 12'hA5C);
    $display("wait-state test done");
  endtask
  task automatic t_bytes();
    measure(1'b0, 1'b1, 12'h3C7);
    measure(1'b1, 1'b1, 12'hFFF);
    $display("two-byte test done");
  endtask
  task automatic t_reset();
    code = 12'h123;
    wmode = 1'b1;
    req = 1'b1;
    repeat (600) @(negedge sys_clk);
    chk(12'h000, {11'h000, bus_if.busy_n});
    arst_n = 1'b0;
    req = 1'b0;
    @(negedge sys_clk);
    chk(12'h002, {10'h000, bus_if.busy_n, bus_if.data_oe});
    arst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
    measure(1'b0, 1'b0, 12'h7E1);
    $display("reset test done");
  endtask
  task automatic t_tick();
    int n;
    n = 0;
    repeat (320) begin
      @(negedge sys_clk);
      if (tick === 1'b1) n++;
    end
    chk(12'h00A, 12'(n));
    $display("tick test done");
  endtask
  initial begin
    repeat (16) @(negedge sys_clk);
    arst_n = 1'b1;
    @(negedge sys_clk);
    t_read_ahead();
    t_wait();
    t_bytes();
    t_reset();
    t_tick();
    close_out();
  end
  initial begin
    #2000000;
    n_errors++;
    close_out();
  end
endmodule
